/* File: lcds_pkg.sv */
package lcds_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_CFG = 8'h00;
   localparam logic [7:0] OFF_CH = 8'h04;
   localparam logic [7:0] OFF_WAIT = 8'h08;
   localparam logic [7:0] OFF_CMD = 8'h0c;
   localparam logic [7:0] OFF_STAT = 8'h10;
   localparam logic [7:0] OFF_TX = 8'h14;
   // cfg fields
   localparam int CFG_IGN = 0;
   localparam int CFG_KEEP = 1;
   localparam int CFG_OFFBYTE = 2;
   localparam int CFG_POL = 3;
   localparam int CFG_MOTION = 4;
   localparam int CFG_FBPOL = 5;
   localparam int CFG_STEN = 6;
   localparam int CFG_STACT = 7;
   localparam int CFG_DBEG = 8;
   localparam int CFG_DEND = 10;
   localparam int CFG_SUPEN = 12;
   localparam int CFG_SUPOBJ = 13;
   localparam int CFG_SDBEG = 14;
   localparam int CFG_SDBYTE = 16;
   localparam logic [31:0] CFG_RST = 32'h0000_0000;
   localparam logic [31:0] CH_RST = 32'h0000_0032;
   // cmd bits
   localparam int CMD_PRES = 0;
   localparam int CMD_DIS = 1;
   localparam int CMD_FBDIS = 2;
   localparam int CMD_MAN = 3;
   localparam int CMD_FBEND = 4;
   // actions
   localparam logic [1:0] DB_SILENT = 2'h0;
   localparam logic [1:0] DB_TEL = 2'h1;
   localparam logic [1:0] DB_STEP = 2'h2;
   localparam logic [1:0] DE_SILENT = 2'h0;
   localparam logic [1:0] DE_OFF = 2'h1;
   localparam logic [1:0] DE_START = 2'h2;
   localparam logic [1:0] SB_OFF = 2'h0;
   localparam logic [1:0] SB_MIN = 2'h1;
   localparam logic [1:0] SB_CFG = 2'h2;
   // telegram kinds on tx register
   localparam logic [2:0] TK_NONE = 3'h0;
   localparam logic [2:0] TK_SW = 3'h1;
   localparam logic [2:0] TK_VAL = 3'h2;
   localparam logic [2:0] TK_STAT = 3'h3;
   localparam logic [2:0] TK_DIM = 3'h4;
   // timing
   localparam int CLK_MHZ = 250;
   localparam int BASE_WAIT_S = 10;
   localparam int TICK_US = 1000000;
   localparam int TICK_CYC = TICK_US * CLK_MHZ;
   localparam int SEC_PER_MIN = 60;
   localparam logic [7:0] MIN_OUT = 8'h01;
   localparam logic [7:0] DIM_DOWN_FULL = 8'h01;
   typedef enum logic [4:0] {
      ST_OFF = 5'b00001,
      ST_START = 5'b00010,
      ST_MAIN = 5'b00100,
      ST_STEP = 5'b01000,
      ST_DIS = 5'b10000
   } lcds_state_t;
endpackage

/* File: lcds_tx_reg.sv */
`timescale 1ns/1ps
`default_nettype none
module lcds_tx_reg (
   // clock
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   // write
   input wire logic we,
   input wire logic [11:0] wdata,
   input wire logic clr,
   // read
   output logic [12:0] rdata
);
   logic [12:0] q;
   // one telegram slot; a new telegram beats the software clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q <= 13'h0000;
      end else if (ce) begin
         if (we) begin
            q <= {1'b1, wdata};
         end else if (clr) begin
            q <= 13'h0000;
         end
      end
   end
   assign rdata = q;
endmodule // lcds_tx_reg
`default_nettype wire

/* File: lcds_top.sv */
`timescale 1ns/1ps
`default_nettype none
module lcds_top #(
   parameter int TICK_CYC = lcds_pkg::TICK_CYC
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // status
   output logic dis_status
);
   logic [31:0] cfg_q, ch_q, wait_q, rdata_q;
   logic [4:0] cmd_q;
   logic aw_q, ar_q;
   logic [7:0] aa_q;
   logic [12:0] tx_rd;
   logic [31:0] tick_q;
   logic [11:0] secs_q;
   logic pres_q, sup_q, dis_q, step_ign_q, restart_q, stat_q;
   logic [11:0] tx_d;
   logic tx_we;
   lcds_pkg::lcds_state_t st_q, st_d;
   // ahb decode
   wire a_ok = hsel & hready & htrans[1];
   wire [31:0] wd = hwdata;
   wire w_cfg = aw_q & (aa_q == lcds_pkg::OFF_CFG);
   wire w_ch = aw_q & (aa_q == lcds_pkg::OFF_CH);
   wire w_wait = aw_q & (aa_q == lcds_pkg::OFF_WAIT);
   wire w_cmd = aw_q & (aa_q == lcds_pkg::OFF_CMD);
   wire w_tx = aw_q & (aa_q == lcds_pkg::OFF_TX);
   // command fields
   wire pres_in = w_cmd ? wd[lcds_pkg::CMD_PRES] : cmd_q[lcds_pkg::CMD_PRES];
   wire raw_dis = w_cmd ? wd[lcds_pkg::CMD_DIS] : cmd_q[lcds_pkg::CMD_DIS];
   wire raw_fbd = w_cmd ? wd[lcds_pkg::CMD_FBDIS] : cmd_q[lcds_pkg::CMD_FBDIS];
   wire man_ev = w_cmd & wd[lcds_pkg::CMD_MAN];
   wire fb_end = w_cmd & wd[lcds_pkg::CMD_FBEND];
   wire motion_blk = cfg_q[lcds_pkg::CFG_MOTION];
   // polarity select: the combined block decides alone
   wire dis_lvl = motion_blk ? (raw_fbd ^ cfg_q[lcds_pkg::CFG_FBPOL])
                      : (raw_dis ^ cfg_q[lcds_pkg::CFG_POL]);
   wire dis_rise = dis_lvl & ~dis_q;
   wire dis_fall = ~dis_lvl & dis_q;
   wire [1:0] dbeg = cfg_q[lcds_pkg::CFG_DBEG +: 2];
   wire [1:0] dend = cfg_q[lcds_pkg::CFG_DEND +: 2];
   wire [1:0] sbeg = cfg_q[lcds_pkg::CFG_SDBEG +: 2];
   wire sup_en = cfg_q[lcds_pkg::CFG_SUPEN];
   wire sup_obj = cfg_q[lcds_pkg::CFG_SUPOBJ];
   wire pres_new = pres_in & ~pres_q;
   wire pres_end = ~pres_in & pres_q;
   // wait = base plus minutes and seconds
   wire [11:0] wait_s = 12'(lcds_pkg::BASE_WAIT_S) + 12'(wait_q[13:8]) * 12'(lcds_pkg::SEC_PER_MIN)
                        + 12'(wait_q[5:0]);
   wire tick = (tick_q == TICK_CYC - 1);
   wire wait_done = (st_q == lcds_pkg::ST_STEP) && tick && (secs_q + 12'h001 >= wait_s);
   wire sup_start = sup_en & man_ev & ~sup_q & ~dis_q;
   wire sup_auto_end = sup_q & ~sup_obj & (motion_blk ? fb_end : pres_end);
   wire stat_now = dis_lvl | (sup_q | sup_start) & ~sup_auto_end & ~dis_fall;
   function automatic logic [11:0] tel(input logic [2:0] k, input logic [7:0] v);
      tel = {1'b0, k, v};
   endfunction
   // next state; one bus write can carry several events; disable end wins, then disable start, manual start, auto end
   // serial event handling
   always_comb begin
      st_d = st_q;
      tx_we = 1'b0;
      tx_d = 12'h000;
      if (dis_fall) begin
         st_d = lcds_pkg::ST_OFF;
         unique case (dend)
            lcds_pkg::DE_OFF: begin
               tx_we = 1'b1;
               tx_d = tel(lcds_pkg::TK_SW, 8'h00);
               if (pres_in) st_d = lcds_pkg::ST_START;
            end
            lcds_pkg::DE_START: st_d = lcds_pkg::ST_START;
            default: st_d = lcds_pkg::ST_OFF;
         endcase
      end else if (dis_rise) begin
         st_d = lcds_pkg::ST_DIS;
         unique case (dbeg)
            lcds_pkg::DB_TEL: begin
               tx_we = 1'b1;
               tx_d = ch_q[8] ? tel(lcds_pkg::TK_VAL, ch_q[7:0])
                              : tel(lcds_pkg::TK_SW, {7'h00, ch_q[9]});
            end
            lcds_pkg::DB_STEP: st_d = lcds_pkg::ST_STEP;
            default: st_d = lcds_pkg::ST_DIS;
         endcase
      end else if (sup_start) begin
         st_d = lcds_pkg::ST_DIS;
      end else if (sup_auto_end) begin
         st_d = lcds_pkg::ST_STEP;
      end else begin
         unique case (st_q)
            lcds_pkg::ST_OFF: if (pres_new) st_d = lcds_pkg::ST_START;
            lcds_pkg::ST_START: st_d = pres_in ? lcds_pkg::ST_MAIN : lcds_pkg::ST_STEP;
            lcds_pkg::ST_MAIN: if (!pres_in) st_d = lcds_pkg::ST_STEP;
            lcds_pkg::ST_STEP: begin
               if (pres_new && !cfg_q[lcds_pkg::CFG_IGN] && !step_ign_q) begin
                  st_d = lcds_pkg::ST_START;
               end else if (wait_done) begin
                  if (!cfg_q[lcds_pkg::CFG_KEEP]) begin
                     tx_we = 1'b1;
                     tx_d = cfg_q[lcds_pkg::CFG_OFFBYTE] ? tel(lcds_pkg::TK_VAL, 8'h00)
                                                         : tel(lcds_pkg::TK_SW, 8'h00);
                  end
                  if (restart_q && !step_ign_q) st_d = lcds_pkg::ST_START;
                  else if (step_ign_q) st_d = lcds_pkg::ST_DIS;
                  else st_d = lcds_pkg::ST_OFF;
               end
            end
            lcds_pkg::ST_DIS: st_d = lcds_pkg::ST_DIS;
         endcase
      end
      if (st_d == lcds_pkg::ST_STEP && st_q != lcds_pkg::ST_STEP && !tx_we) begin
         tx_we = 1'b1;
         unique case (sbeg)
            lcds_pkg::SB_MIN: tx_d = cfg_q[lcds_pkg::CFG_SDBYTE] ? tel(lcds_pkg::TK_VAL, lcds_pkg::MIN_OUT)
                                                                 : tel(lcds_pkg::TK_DIM, lcds_pkg::DIM_DOWN_FULL);
            lcds_pkg::SB_CFG: tx_d = tel(lcds_pkg::TK_VAL, ch_q[23:16]);
            default: tx_d = tel(lcds_pkg::TK_SW, 8'h00);
         endcase
      end
      if (!tx_we && cfg_q[lcds_pkg::CFG_STEN] && cfg_q[lcds_pkg::CFG_STACT] && stat_now != stat_q) begin
         tx_we = 1'b1;
         tx_d = tel(lcds_pkg::TK_STAT, {7'h00, stat_now});
      end
   end
   // bus address phase capture
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         aw_q <= 1'b0;
         ar_q <= 1'b0;
         aa_q <= 8'h00;
      end else if (ce) begin
         aw_q <= a_ok & hwrite;
         ar_q <= a_ok & ~hwrite;
         aa_q <= haddr[7:0];
      end
   end
   // software registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_q <= lcds_pkg::CFG_RST;
         ch_q <= lcds_pkg::CH_RST;
         wait_q <= 32'h0000_0000;
         cmd_q <= 5'h00;
      end else if (ce) begin
         if (w_cfg) cfg_q <= wd;
         if (w_ch) ch_q <= wd;
         if (w_wait) wait_q <= wd;
         if (w_cmd) cmd_q <= {2'b00, wd[2:0]};
      end
   end
   // read mux, registered on the address phase
   wire [7:0] ra = haddr[7:0];
   wire [31:0] rmux = (ra == lcds_pkg::OFF_CFG) ? cfg_q :
                      (ra == lcds_pkg::OFF_CH) ? ch_q :
                      (ra == lcds_pkg::OFF_WAIT) ? wait_q :
                      (ra == lcds_pkg::OFF_CMD) ? {27'h0, cmd_q} :
                      (ra == lcds_pkg::OFF_STAT) ? {20'h0, secs_q[6:0], st_q} :
                      (ra == lcds_pkg::OFF_TX) ? {19'h0, tx_rd} : 32'h0000_0000;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata_q <= 32'h0000_0000;
      end else if (ce && a_ok && !hwrite) begin
         rdata_q <= {rmux[31:1], (ra == lcds_pkg::OFF_STAT) ? stat_q : rmux[0]};
      end
   end
   // control state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q <= lcds_pkg::ST_OFF;
         pres_q <= 1'b0;
         dis_q <= 1'b0;
         sup_q <= 1'b0;
         step_ign_q <= 1'b0;
         restart_q <= 1'b0;
         stat_q <= 1'b0;
      end else if (ce) begin
         st_q <= st_d;
         pres_q <= pres_in;
         dis_q <= dis_lvl;
         // the disable end always ends it; the auto end only when sup_obj is clear
         // ended by presence end (feedback end with CFG_MOTION) or disable end
         if (dis_fall | sup_auto_end) sup_q <= 1'b0;
         else if (sup_start) sup_q <= 1'b1;
         if (dis_rise) step_ign_q <= (dbeg == lcds_pkg::DB_STEP);
         else if (dis_fall | wait_done) step_ign_q <= 1'b0;
         if (st_d == lcds_pkg::ST_STEP && st_q != lcds_pkg::ST_STEP) restart_q <= 1'b0;
         else if (pres_new) restart_q <= 1'b1;
         else if (!pres_in) restart_q <= 1'b0;
         stat_q <= stat_now & cfg_q[lcds_pkg::CFG_STEN];
      end
   end
   // waiting time counter
   // base plus configured wait
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tick_q <= 32'h0;
         secs_q <= 12'h000;
      end else if (ce) begin
         if (st_q != lcds_pkg::ST_STEP || st_d != lcds_pkg::ST_STEP) begin
            tick_q <= 32'h0;
            secs_q <= 12'h000;
         end else if (tick) begin
            tick_q <= 32'h0;
            secs_q <= secs_q + 12'h001;
         end else begin
            tick_q <= tick_q + 32'h1;
         end
      end
   end
   lcds_tx_reg u_tx (
      .hclk(hclk),
      .hresetn(hresetn),
      .ce(ce),
      .we(tx_we),
      .wdata(tx_d),
      .clr(w_tx),
      .rdata(tx_rd)
   );
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdata_q;
   assign dis_status = stat_q;
   a_stat_follow: assert property (@(posedge hclk) disable iff (!hresetn)
      ce && cfg_q[lcds_pkg::CFG_STEN] && dis_lvl |=> dis_status)
      else $error("status not set while disabled");
   a_end_reset: assert property (@(posedge hclk) disable iff (!hresetn)
      ce && dis_fall && dend == lcds_pkg::DE_SILENT |=> st_q == lcds_pkg::ST_OFF)
      else $error("state not off after enable");
   a_dis_step: assert property (@(posedge hclk) disable iff (!hresetn)
      ce && dis_rise && dbeg == lcds_pkg::DB_STEP |=> st_q == lcds_pkg::ST_STEP)
      else $error("step-down not entered on disable");
   a_dis_silent: assert property (@(posedge hclk) disable iff (!hresetn)
      ce && dis_rise && dbeg == lcds_pkg::DB_SILENT && !cfg_q[lcds_pkg::CFG_STACT] |-> !tx_we)
      else $error("telegram on silent disable");
   a_cancel: assert property (@(posedge hclk) disable iff (!hresetn)
      ce && st_q == lcds_pkg::ST_STEP && pres_new && !cfg_q[lcds_pkg::CFG_IGN] && !step_ign_q
      && !dis_lvl && !dis_q && !sup_start && !sup_auto_end |=> st_q == lcds_pkg::ST_START)
      else $error("step-down not cancelled");
   a_ignore: assert property (@(posedge hclk) disable iff (!hresetn)
      ce && st_q == lcds_pkg::ST_STEP && cfg_q[lcds_pkg::CFG_IGN] && !wait_done && !dis_lvl
      && !dis_q && !sup_start && !sup_auto_end |=> st_q == lcds_pkg::ST_STEP)
      else $error("step-down left while ignoring");
   a_en_off: assert property (@(posedge hclk) disable iff (!hresetn)
      ce && dis_fall && dend == lcds_pkg::DE_OFF |=> tx_rd[12] && tx_rd[10:8] == lcds_pkg::TK_SW)
      else $error("no switch-off on enable");
   a_manual: assert property (@(posedge hclk) disable iff (!hresetn)
      ce && sup_start && !dis_lvl |=> st_q == lcds_pkg::ST_DIS && sup_q)
      else $error("manual input ignored");
   c_step: cover property (@(posedge hclk) st_q == lcds_pkg::ST_STEP);
   c_dis: cover property (@(posedge hclk) dis_rise);
   c_sup: cover property (@(posedge hclk) sup_start);
endmodule // lcds_top
`default_nettype wire

/* File: lcds_bus_model.sv */
`timescale 1ns/1ps
`default_nettype none
module lcds_bus_model (
   // clock
   input wire logic hclk,
   input wire logic hresetn,
   // status seen on the building bus
   input wire logic dis_status,
   // activity
   output logic [7:0] n_edges_q
);
   logic last_q;
   // presence end or enable is sent by the bench as a bus input
   // feedback linkage is passive here, only status edges are tracked
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         last_q <= 1'b0;
         n_edges_q <= 8'h00;
      end else begin
         last_q <= dis_status;
         if (last_q != dis_status) begin
            n_edges_q <= n_edges_q + 8'h01;
         end
      end
   end
endmodule // lcds_bus_model
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, dis_status;
   logic [31:0] haddr, hwdata, hrdata, r;
   logic [1:0] htrans;
   logic [2:0] hsize;
   int errors, n_checks;
   lcds_top #(.TICK_CYC(4)) lcds_top_i (.hclk(hclk), .hresetn(hresetn), .ce(1'b1),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .dis_status(dis_status));
   lcds_bus_model lcds_bus_model_i (.hclk(hclk), .hresetn(hresetn),
      .dis_status(dis_status), .n_edges_q());
   initial begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end
   task automatic test_done();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge hclk);
   endtask
   task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
      int n;
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h000000, a};
      hwrite <= w;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      xf(1'b1, a, d, x);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] x;
      xf(1'b0, a, 32'h00000000, x);
      chk(x, e);
   endtask
   task automatic cd(input logic [31:0] cfg, input logic [31:0] cmd, input logic e);
      wr(lcds_pkg::OFF_CFG, cfg);
      wr(lcds_pkg::OFF_CMD, cmd);
      wt(3);
      chk({31'h0, dis_status}, {31'h0, e});
   endtask
   function automatic logic [31:0] tel(input logic [2:0] k, input logic [7:0] v);
      return {19'h00000, 1'b1, 1'b0, k, v};
   endfunction
   task automatic step_in(input logic [31:0] cfg);
      wr(lcds_pkg::OFF_CFG, cfg);
      wr(lcds_pkg::OFF_CMD, 32'h00000001);
      wt(3);
      wr(lcds_pkg::OFF_CMD, 32'h00000000);
      wt(2);
      xf(1'b0, lcds_pkg::OFF_STAT, 32'h0, r);
      chk({31'h0, r[3]}, 32'h00000001);
      wr(lcds_pkg::OFF_TX, 32'h00000000);
   endtask
   initial begin
      errors = 0;
      n_checks = 0;
      hresetn = 1'b0;
      hsel = 1'b0;
      htrans = 2'h0;
      haddr = 32'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      wt(20);
      hresetn <= 1'b1;
      wt(1);
      rc(lcds_pkg::OFF_CFG, lcds_pkg::CFG_RST);
      rc(lcds_pkg::OFF_CH, lcds_pkg::CH_RST);
      rc(8'h18, 32'h00000000);
      chk({31'h0, hresp}, 32'h0);
      chk({31'h0, hreadyout}, 32'h00000001);
      cd(32'h00000040, 32'h00000002, 1'b1);
      cd(32'h00000040, 32'h00000000, 1'b0);
      cd(32'h00000048, 32'h00000000, 1'b1);
      cd(32'h00000048, 32'h00000002, 1'b0);
      cd(32'h00000050, 32'h00000002, 1'b0);
      cd(32'h00000050, 32'h00000004, 1'b1);
      cd(32'h00000040, 32'h00000000, 1'b0);
      wr(lcds_pkg::OFF_TX, 32'h0);
      cd(32'h00000040, 32'h00000002, 1'b1);
      rc(lcds_pkg::OFF_TX, 32'h0);
      cd(32'h00000100, 32'h00000000, 1'b0);
      wr(lcds_pkg::OFF_CH, 32'h00000200);
      wr(lcds_pkg::OFF_TX, 32'h0);
      wr(lcds_pkg::OFF_CMD, 32'h00000002);
      rc(lcds_pkg::OFF_TX, tel(lcds_pkg::TK_SW, 8'h01));
      wr(lcds_pkg::OFF_CMD, 32'h00000000);
      wr(lcds_pkg::OFF_CH, 32'h00000132);
      wr(lcds_pkg::OFF_TX, 32'h0);
      wr(lcds_pkg::OFF_CMD, 32'h00000002);
      rc(lcds_pkg::OFF_TX, tel(lcds_pkg::TK_VAL, 8'h32));
      wr(lcds_pkg::OFF_CFG, 32'h00000500);
      wr(lcds_pkg::OFF_TX, 32'h0);
      wr(lcds_pkg::OFF_CMD, 32'h00000000);
      rc(lcds_pkg::OFF_TX, tel(lcds_pkg::TK_SW, 8'h00));
      xf(1'b0, lcds_pkg::OFF_STAT, 32'h0, r);
      chk({31'h0, r[4]}, 32'h0);
      wr(lcds_pkg::OFF_CFG, 32'h000000c0);
      wr(lcds_pkg::OFF_TX, 32'h0);
      wr(lcds_pkg::OFF_CMD, 32'h00000002);
      wt(2);
      rc(lcds_pkg::OFF_TX, tel(lcds_pkg::TK_STAT, 8'h01));
      cd(32'h00000040, 32'h00000000, 1'b0);
      cd(32'h00003040, 32'h00000008, 1'b1);
      cd(32'h00003040, 32'h00000001, 1'b1);
      cd(32'h00003040, 32'h00000000, 1'b1);
      cd(32'h00003040, 32'h00000002, 1'b1);
      cd(32'h00003040, 32'h00000000, 1'b0);
      cd(32'h00001040, 32'h00000009, 1'b1);
      cd(32'h00001040, 32'h00000000, 1'b0);
      step_in(32'h00004000);
      wt(25);
      rc(lcds_pkg::OFF_TX, 32'h0);
      wt(30);
      rc(lcds_pkg::OFF_TX, tel(lcds_pkg::TK_SW, 8'h00));
      step_in(32'h00004004);
      wt(55);
      rc(lcds_pkg::OFF_TX, tel(lcds_pkg::TK_VAL, 8'h00));
      step_in(32'h00004002);
      wt(55);
      rc(lcds_pkg::OFF_TX, 32'h0);
      wr(lcds_pkg::OFF_CMD, 32'h00000000);
      step_in(32'h00004000);
      wr(lcds_pkg::OFF_CMD, 32'h00000001);
      wt(1);
      xf(1'b0, lcds_pkg::OFF_STAT, 32'h0, r);
      chk({31'h0, r[3]}, 32'h0);
      wr(lcds_pkg::OFF_CMD, 32'h00000000);
      step_in(32'h00004001);
      wr(lcds_pkg::OFF_CMD, 32'h00000001);
      wt(1);
      xf(1'b0, lcds_pkg::OFF_STAT, 32'h0, r);
      chk({31'h0, r[3]}, 32'h00000001);
      wt(60);
      xf(1'b0, lcds_pkg::OFF_STAT, 32'h0, r);
      chk({31'h0, r[1] | r[2]}, 32'h00000001);
      test_done();
   end
   initial begin
      #100us;
      errors++;
      test_done();
   end
endmodule // tb_top
`default_nettype wire
